// >>> logic/uad_cfg.svh
// Purpose: Offsets, field positions, reset values and timing counts of the data port.
// Assumes: Byte addresses on a 32-bit address port, 16-bit register data.
// Notes:   Included by bare name wherever a figure is needed.
`ifndef UAD_CFG_SVH
`define UAD_CFG_SVH

`define UAD_ADDR_DATA         32'h50001000
`define UAD_ADDR_IER_DLH      32'h50001004
`define UAD_ADDR_FIFO_CTRL    32'h50001008
`define UAD_ADDR_LINE_CTRL    32'h5000100c
`define UAD_ADDR_LINE_STATUS  32'h50001014
`define UAD_ADDR_INT_STATUS   32'h500010d0
`define UAD_ADDR_INT_MASK     32'h500010d4

`define UAD_LC_DIV_ACCESS     7
`define UAD_FC_ENABLE         0
`define UAD_FC_RX_FLUSH       1
`define UAD_FC_TX_FLUSH       2
`define UAD_LS_DATA_READY     0
`define UAD_LS_OVERRUN        1
`define UAD_LS_HOLD_EMPTY     5
`define UAD_LS_TX_EMPTY       6
`define UAD_IS_RX             0
`define UAD_IS_OVERRUN        1
`define UAD_IS_HOLD_EMPTY     2

`define UAD_RESET_DATA        16'h0000
`define UAD_RESET_DIVISOR     16'h0000
`define UAD_RESET_BYTE        8'h00
`define UAD_RESET_INT         3'h0

`define UAD_OVERSAMPLE        16
`define UAD_HALF_BIT          8
`define UAD_DATA_BITS         8
`define UAD_FIFO_DEPTH        16

`endif

// >>> logic/uad_pkg.sv
// Purpose: Types shared by the data port modules.
// Assumes: Nothing beyond the configuration header.
// Notes:   State encodings are left to the tools.
package uad_pkg;
   typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} uad_tx_state_t;
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} uad_rx_state_t;
endpackage

// >>> logic/uad_ser_if.sv
// Purpose: Carries characters and the divisor between the register side and the serial engine.
// Assumes: Both ends on mclk.
// Notes:   txValid/txReady is a plain handshake; rxValid is a one-cycle pulse.
`timescale 1ns/100ps
interface uad_ser_if;
   logic [15:0] divisor;
   logic        txValid;
   logic [7:0]  txData;
   logic        txReady;
   logic        txBusy;
   logic        rxValid;
   logic [7:0]  rxData;
   modport core   (output divisor, txValid, txData, input txReady, txBusy, rxValid, rxData);
   modport engine (input divisor, txValid, txData, output txReady, txBusy, rxValid, rxData);
endinterface

// >>> logic/uad_fifo.sv
// Purpose: Synchronous character FIFO with valid/ready on both sides.
// Assumes: Same clock on both sides; flush empties it in one cycle.
// Notes:   A write while full is refused through wrReady and is lost by the caller.
`timescale 1ns/100ps
`include "uad_cfg.svh"
module uad_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = `UAD_FIFO_DEPTH
) (
   input  wire logic             mclk,    // System clock.
   input  wire logic             nrst,    // Synchronous reset, active low.
   input  wire logic             ce,      // Clock enable.
   input  wire logic             flush,   // Empty the FIFO.
   input  wire logic             wrValid, // Push request.
   output logic                  wrReady, // Room for one more.
   input  wire logic [WIDTH-1:0] wrData,  // Pushed character.
   output logic                  rdValid, // Head is valid.
   input  wire logic             rdReady, // Pop the head.
   output logic      [WIDTH-1:0] rdData   // Head character.
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   if (DEPTH < 2 || WIDTH < 1) begin : g_check
      $error("uad_fifo needs DEPTH of at least 2 and WIDTH of at least 1");
   end

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0]    wrPtr, rdPtr, next_wrPtr, next_rdPtr;
   logic [CW-1:0]    count, next_count;
   logic             push, pop;

   function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
      return (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction

   assign wrReady = (count != CW'(DEPTH));
   assign rdValid = (count != '0);
   assign rdData  = mem[rdPtr];
   assign push    = wrValid && wrReady;
   assign pop     = rdReady && rdValid;

   always_comb begin
      next_wrPtr = push ? bump(wrPtr) : wrPtr;
      next_rdPtr = pop ? bump(rdPtr) : rdPtr;
      next_count = count + CW'(push) - CW'(pop);
      if (flush) begin
         next_wrPtr = '0;
         next_rdPtr = '0;
         next_count = '0;
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         wrPtr <= '0;
         rdPtr <= '0;
         count <= '0;
      end else if (ce) begin
         wrPtr <= next_wrPtr;
         rdPtr <= next_rdPtr;
         count <= next_count;
         if (push && !flush) begin
            mem[wrPtr] <= wrData;
         end
      end
   end
endmodule

// >>> logic/uad_serial.sv
// Purpose: Baud generator and 8N1 transmit/receive engines.
// Assumes: rxd is asynchronous and is synchronised here.
// Notes:   One bit lasts sixteen baud ticks; a zero divisor stops every tick.
`timescale 1ns/100ps
`include "uad_cfg.svh"
module uad_serial
   import uad_pkg::*;
(
   input  wire logic mclk, // System clock.
   input  wire logic nrst, // Synchronous reset, active low.
   input  wire logic ce,   // Clock enable.
   uad_ser_if.engine ser,  // Characters and divisor.
   input  wire logic rxd,  // Serial input pin.
   output logic      txd   // Serial output pin.
);
   logic [15:0]   baudCnt, next_baudCnt;
   logic          baudTick, divOn;
   logic [1:0]    rxSync;
   uad_tx_state_t txState, next_txState;
   uad_rx_state_t rxState, next_rxState;
   logic [3:0]    txTicks, next_txTicks, rxTicks, next_rxTicks;
   logic [2:0]    txBit, next_txBit, rxBit, next_rxBit;
   logic [7:0]    txShift, next_txShift, rxShift, next_rxShift;
   logic          next_txd, next_rxValid;
   logic [7:0]    next_rxData;

   assign divOn       = (ser.divisor != 16'h0000);
   assign baudTick    = divOn && (baudCnt == ser.divisor - 16'h0001);
   assign ser.txReady = (txState == TX_IDLE) && divOn;
   assign ser.txBusy  = (txState != TX_IDLE);

   always_comb begin
      next_baudCnt = divOn ? (baudTick ? 16'h0000 : baudCnt + 16'h0001) : 16'h0000;
      next_txState = txState;
      next_txTicks = txTicks;
      next_txBit   = txBit;
      next_txShift = txShift;
      next_txd     = txd;
      if (ser.txReady && ser.txValid) begin
         next_txState = TX_START;
         next_txTicks = 4'h0;
         next_txShift = ser.txData;
      end else if (baudTick && txState != TX_IDLE) begin
         next_txTicks = txTicks + 4'h1;
         unique case (txState)
            TX_START: next_txd = 1'b0;
            TX_DATA:  next_txd = txShift[0];
            TX_STOP:  next_txd = 1'b1;
            TX_IDLE:  next_txd = 1'b1;
         endcase
         if (txTicks == 4'(`UAD_OVERSAMPLE - 1)) begin
            unique case (txState)
               TX_START: begin
                  next_txState = TX_DATA;
                  next_txBit   = 3'h0;
               end
               TX_DATA: begin
                  next_txShift = {1'b0, txShift[7:1]};
                  next_txBit   = txBit + 3'h1;
                  if (txBit == 3'(`UAD_DATA_BITS - 1)) begin
                     next_txState = TX_STOP;
                  end
               end
               TX_STOP:  next_txState = TX_IDLE;
               TX_IDLE:  next_txState = TX_IDLE;
            endcase
         end
      end else if (txState == TX_IDLE) begin
         next_txd = 1'b1;
      end
   end

   always_comb begin
      next_rxState = rxState;
      next_rxTicks = rxTicks;
      next_rxBit   = rxBit;
      next_rxShift = rxShift;
      next_rxValid = 1'b0;
      next_rxData  = ser.rxData;
      if (baudTick) begin
         next_rxTicks = rxTicks + 4'h1;
         unique case (rxState)
            RX_IDLE: begin
               next_rxTicks = 4'h0;
               if (!rxSync[1]) begin
                  next_rxState = RX_START;
               end
            end
            RX_START: begin
               if (rxTicks == 4'(`UAD_HALF_BIT - 1)) begin
                  // Realign to mid-bit so that later samples sit in the bit centre.
                  next_rxTicks = 4'h0;
                  next_rxBit   = 3'h0;
                  next_rxState = rxSync[1] ? RX_IDLE : RX_DATA;
               end
            end
            RX_DATA: begin
               if (rxTicks == 4'(`UAD_OVERSAMPLE - 1)) begin
                  next_rxShift = {rxSync[1], rxShift[7:1]};
                  next_rxBit   = rxBit + 3'h1;
                  if (rxBit == 3'(`UAD_DATA_BITS - 1)) begin
                     next_rxState = RX_STOP;
                  end
               end
            end
            RX_STOP: begin
               if (rxTicks == 4'(`UAD_OVERSAMPLE - 1)) begin
                  // A character with a bad stop bit is dropped.
                  next_rxValid = rxSync[1];
                  next_rxData  = rxShift;
                  next_rxState = RX_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         baudCnt     <= 16'h0000;
         rxSync      <= 2'b11;
         txState     <= TX_IDLE;
         txTicks     <= 4'h0;
         txBit       <= 3'h0;
         txShift     <= 8'h00;
         txd         <= 1'b1;
         rxState     <= RX_IDLE;
         rxTicks     <= 4'h0;
         rxBit       <= 3'h0;
         rxShift     <= 8'h00;
         ser.rxValid <= 1'b0;
         ser.rxData  <= 8'h00;
      end else if (ce) begin
         baudCnt     <= next_baudCnt;
         rxSync      <= {rxSync[0], rxd};
         txState     <= next_txState;
         txTicks     <= next_txTicks;
         txBit       <= next_txBit;
         txShift     <= next_txShift;
         txd         <= next_txd;
         rxState     <= next_rxState;
         rxTicks     <= next_rxTicks;
         rxBit       <= next_rxBit;
         rxShift     <= next_rxShift;
         ser.rxValid <= next_rxValid;
         ser.rxData  <= next_rxData;
      end
   end
endmodule

// >>> logic/uad_data_port.sv
// Purpose: Data and divisor port of a serial controller with optional FIFOs.
// Assumes: Plain register port, read data one cycle after the read strobe.
// Notes:   Line framing is fixed at eight data bits, no parity, one stop bit.
//
// The plain strobed port was left to the implementer.
`timescale 1ns/100ps
`include "uad_cfg.svh"
module uad_data_port
   import uad_pkg::*;
#(
   parameter int FIFO_DEPTH = `UAD_FIFO_DEPTH
) (
   input  wire logic        mclk,   // System clock, 20 MHz.
   input  wire logic        nrst,   // Synchronous reset, active low.
   input  wire logic        ce,     // Clock enable; low freezes all state.
   input  wire logic [31:0] addr,   // Register byte address.
   input  wire logic [15:0] wdata,  // Write data.
   input  wire logic        wrStb,  // Write strobe, one cycle.
   input  wire logic        rdStb,  // Read strobe, one cycle.
   output logic      [15:0] rdata,  // Read data, valid the cycle after rdStb.
   input  wire logic        rxd,    // Serial input pin.
   output logic             txd,    // Serial output pin.
   output logic             irq     // Interrupt, level, active high.
);
   if (FIFO_DEPTH < 2) begin : g_check
      $error("uad_data_port needs FIFO_DEPTH of at least 2");
   end

   // Characters and divisor to the engine.
   uad_ser_if ser ();

   logic [7:0]  lineControl, next_lineControl;
   logic        fifoEnable, next_fifoEnable;
   logic [15:0] divisor, next_divisor;
   logic [7:0]  intEnable, next_intEnable;

   logic [7:0]  rxBuffer, next_rxBuffer;
   logic        rxReady, next_rxReady;

   logic [7:0]  txHolding, next_txHolding;
   logic        holdEmpty, next_holdEmpty;

   logic        overrun, next_overrun;
   logic [2:0]  intStatus, next_intStatus;
   logic [2:0]  intMask, next_intMask;
   logic        prevEmpty, next_prevEmpty;

   logic [15:0] next_rdata;

   logic        divAccess, dataWrite, dataRead, fifoCtrlWrite;

   logic        rxFlush, txFlush, rxPush, rxFifoReady, rxFifoValid, rxPop;

   logic        txPush, txFifoReady, txFifoValid, txPop, txTaken;
   logic [7:0]  rxFifoData, txFifoData;
   logic        dataReadyFlag, holdEmptyFlag, overrunEvent;

   function automatic logic hit(input logic [31:0] a, input logic [31:0] offset);
      return a == offset;
   endfunction

   assign divAccess     = lineControl[`UAD_LC_DIV_ACCESS];

   assign dataWrite     = wrStb && hit(addr, `UAD_ADDR_DATA) && !divAccess;
   assign dataRead      = rdStb && hit(addr, `UAD_ADDR_DATA) && !divAccess;

   assign fifoCtrlWrite = wrStb && hit(addr, `UAD_ADDR_FIFO_CTRL);
   // Changing the FIFO mode empties both FIFOs so no stale characters survive.
   assign rxFlush = fifoCtrlWrite
                    && (wdata[`UAD_FC_RX_FLUSH] || wdata[`UAD_FC_ENABLE] != fifoEnable);
   assign txFlush = fifoCtrlWrite
                    && (wdata[`UAD_FC_TX_FLUSH] || wdata[`UAD_FC_ENABLE] != fifoEnable);

   assign rxPush = fifoEnable && ser.rxValid;
   assign rxPop  = fifoEnable && dataRead;
   // A push into a full transmit FIFO is lost.
   assign txPush = fifoEnable && dataWrite;
   assign txPop  = fifoEnable && ser.txReady;

   assign ser.divisor = divisor;
   assign ser.txValid = fifoEnable ? txFifoValid : !holdEmpty;
   assign ser.txData  = fifoEnable ? txFifoData : txHolding;
   assign txTaken     = ser.txValid && ser.txReady;

   assign dataReadyFlag = fifoEnable ? rxFifoValid : rxReady;
   assign holdEmptyFlag = fifoEnable ? !txFifoValid : holdEmpty;
   // With the FIFO off, a read in the arrival cycle frees the buffer in time.
   assign overrunEvent  = ser.rxValid
                          && (fifoEnable ? !rxFifoReady : (rxReady && !dataRead));
   assign irq = |(intStatus & intMask);

   uad_fifo #(
      .WIDTH (8),
      .DEPTH (FIFO_DEPTH)
   ) u_rx_fifo (
      .mclk    (mclk),
      .nrst    (nrst),
      .ce      (ce),
      .flush   (rxFlush),
      .wrValid (rxPush),
      .wrReady (rxFifoReady),
      .wrData  (ser.rxData),
      .rdValid (rxFifoValid),
      .rdReady (rxPop),
      .rdData  (rxFifoData)
   );

   uad_fifo #(
      .WIDTH (8),
      .DEPTH (FIFO_DEPTH)
   ) u_tx_fifo (
      .mclk    (mclk),
      .nrst    (nrst),
      .ce      (ce),
      .flush   (txFlush),
      .wrValid (txPush),
      .wrReady (txFifoReady),
      .wrData  (wdata[7:0]),
      .rdValid (txFifoValid),
      .rdReady (txPop),
      .rdData  (txFifoData)
   );

   uad_serial u_serial (
      .mclk (mclk),
      .nrst (nrst),
      .ce   (ce),
      .ser  (ser.engine),
      .rxd  (rxd),
      .txd  (txd)
   );

   always_comb begin
      next_lineControl = lineControl;
      next_fifoEnable  = fifoEnable;
      next_divisor     = divisor;
      next_intEnable   = intEnable;
      next_intMask     = intMask;

      if (wrStb) begin
         // Only bits 7:0 of a write are kept.
         if (hit(addr, `UAD_ADDR_DATA) && divAccess) begin
            next_divisor[7:0] = wdata[7:0];
         end

         if (hit(addr, `UAD_ADDR_IER_DLH)) begin
            if (divAccess) begin
               next_divisor[15:8] = wdata[7:0];
            end else begin
               next_intEnable = wdata[7:0];
            end
         end

         if (hit(addr, `UAD_ADDR_LINE_CTRL)) begin
            next_lineControl = wdata[7:0];
         end

         if (fifoCtrlWrite) begin
            next_fifoEnable = wdata[`UAD_FC_ENABLE];
         end

         if (hit(addr, `UAD_ADDR_INT_MASK)) begin
            next_intMask = wdata[2:0];
         end
      end
   end

   always_comb begin
      next_rxBuffer = rxBuffer;
      next_rxReady  = rxReady;

      if (dataRead && !fifoEnable) begin
         next_rxReady = 1'b0;
      end

      if (ser.rxValid && !fifoEnable) begin
         next_rxBuffer = ser.rxData;
         next_rxReady  = 1'b1;
      end

      if (fifoCtrlWrite) begin
         next_rxReady = 1'b0;
      end
   end

   always_comb begin
      next_txHolding = txHolding;
      next_holdEmpty = holdEmpty;

      if (txTaken && !fifoEnable) begin
         next_holdEmpty = 1'b1;
      end

      if (dataWrite && !fifoEnable) begin
         // A write before the engine takes the character replaces it.
         next_txHolding = wdata[7:0];
         next_holdEmpty = 1'b0;
      end

      if (fifoCtrlWrite) begin
         next_holdEmpty = 1'b1;
      end
   end

   always_comb begin
      next_overrun   = overrun;
      next_intStatus = intStatus;
      next_prevEmpty = holdEmptyFlag;

      if (rdStb && hit(addr, `UAD_ADDR_LINE_STATUS)) begin
         next_overrun = 1'b0;
      end
      if (rdStb && hit(addr, `UAD_ADDR_INT_STATUS)) begin
         next_intStatus = 3'h0;
      end

      // Events are applied after the clears so a same-cycle event is kept.
      if (overrunEvent) begin
         next_overrun                    = 1'b1;
         next_intStatus[`UAD_IS_OVERRUN] = 1'b1;
      end
      if (ser.rxValid) begin
         next_intStatus[`UAD_IS_RX] = 1'b1;
      end
      if (holdEmptyFlag && !prevEmpty) begin
         next_intStatus[`UAD_IS_HOLD_EMPTY] = 1'b1;
      end
   end

   // Read data stand one cycle, zero otherwise.
   always_comb begin
      next_rdata = 16'h0000;
      if (rdStb) begin
         unique case (addr)
            `UAD_ADDR_DATA: begin
               if (divAccess) begin
                  next_rdata = {8'h00, divisor[7:0]};
               end else if (fifoEnable) begin
                  next_rdata = {8'h00, rxFifoValid ? rxFifoData : 8'h00};
               end else begin
                  next_rdata = {8'h00, rxBuffer};
               end
            end
            `UAD_ADDR_IER_DLH: begin
               next_rdata = {8'h00, divAccess ? divisor[15:8] : intEnable};
            end
            `UAD_ADDR_FIFO_CTRL:   next_rdata = {15'h0000, fifoEnable};
            `UAD_ADDR_LINE_CTRL:   next_rdata = {8'h00, lineControl};
            `UAD_ADDR_LINE_STATUS: begin
               next_rdata[`UAD_LS_DATA_READY] = dataReadyFlag;
               next_rdata[`UAD_LS_OVERRUN]    = overrun;
               next_rdata[`UAD_LS_HOLD_EMPTY] = holdEmptyFlag;
               next_rdata[`UAD_LS_TX_EMPTY]   = holdEmptyFlag && !ser.txBusy;
            end
            `UAD_ADDR_INT_STATUS:  next_rdata = {13'h0000, intStatus};
            `UAD_ADDR_INT_MASK:    next_rdata = {13'h0000, intMask};
            default:               next_rdata = 16'h0000;
         endcase
      end
   end

   // Low ce holds all state, FIFOs and engine too.
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         lineControl <= `UAD_RESET_BYTE;
         fifoEnable  <= 1'b0;
         divisor     <= `UAD_RESET_DIVISOR;
         intEnable   <= `UAD_RESET_BYTE;
         intMask     <= `UAD_RESET_INT;
         rxBuffer    <= `UAD_RESET_BYTE;
         rxReady     <= 1'b0;
         txHolding   <= `UAD_RESET_BYTE;
         holdEmpty   <= 1'b1;
         overrun     <= 1'b0;
         intStatus   <= `UAD_RESET_INT;
         prevEmpty   <= 1'b1;
         rdata       <= `UAD_RESET_DATA;
      end else if (ce) begin
         lineControl <= next_lineControl;
         fifoEnable  <= next_fifoEnable;
         divisor     <= next_divisor;
         intEnable   <= next_intEnable;
         intMask     <= next_intMask;
         rxBuffer    <= next_rxBuffer;
         rxReady     <= next_rxReady;
         txHolding   <= next_txHolding;
         holdEmpty   <= next_holdEmpty;
         overrun     <= next_overrun;
         intStatus   <= next_intStatus;
         prevEmpty   <= next_prevEmpty;
         rdata       <= next_rdata;
      end
   end
endmodule

// >>> tb/uad_data_port_chk.sv
// Purpose: Port assertions for the data port.
// Assumes: Divisor and mask change only through bus writes.
// Notes:   Shadow copies are rebuilt from the strobes, so no internal probe is needed.
`timescale 1ns/100ps
`include "uad_cfg.svh"
module uad_data_port_chk (
   input wire logic        mclk,  // Clock.
   input wire logic        nrst,  // Reset.
   input wire logic        ce,    // Enable.
   input wire logic [31:0] addr,  // Address.
   input wire logic [15:0] wdata, // Write data.
   input wire logic        wrStb, // Write strobe.
   input wire logic        rdStb, // Read strobe.
   input wire logic [15:0] rdata, // Read data.
   input wire logic        rxd,   // Serial in.
   input wire logic        txd,   // Serial out.
   input wire logic        irq    // Interrupt.
);
   logic [15:0] div, next_div;
   logic [2:0]  msk, next_msk;
   logic        acc, next_acc, rdLo, rdHi, rdNone;
   assign rdLo = rdStb && acc && addr == `UAD_ADDR_DATA;
   assign rdHi = rdStb && acc && addr == `UAD_ADDR_IER_DLH;
   assign rdNone = rdStb && addr == 32'h50001010;
   always_comb begin
      next_div = nrst ? div : 16'h0000;
      next_msk = nrst ? msk : 3'h0;
      next_acc = nrst && acc;
      if (nrst && wrStb && addr == `UAD_ADDR_LINE_CTRL) next_acc = wdata[7];
      if (nrst && wrStb && addr == `UAD_ADDR_INT_MASK) next_msk = wdata[2:0];
      if (nrst && wrStb && acc && addr == `UAD_ADDR_DATA) next_div[7:0] = wdata[7:0];
      if (nrst && wrStb && acc && addr == `UAD_ADDR_IER_DLH) next_div[15:8] = wdata[7:0];
   end
   always_ff @(posedge mclk) begin
      if (ce || !nrst) begin
         div <= next_div;
         msk <= next_msk;
         acc <= next_acc;
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);
   a_upper_zero: assert property (rdata[15:8] == 8'h00)
      else $error("upper read bits not zero");
   a_rdata_rest: assert property (!$past(rdStb) |-> rdata == 16'h0000)
      else $error("read data outside its cycle");
   a_div_low: assert property ($past(rdLo) |-> rdata == ($past(div) & 16'h00ff))
      else $error("divisor low readback wrong");
   a_div_high: assert property ($past(rdHi) |-> rdata == ($past(div) >> 8))
      else $error("divisor high readback wrong");
   a_no_map: assert property ($past(rdNone) |-> rdata == 16'h0000)
      else $error("unmapped read not zero");
   a_zero_quiet: assert property (div == 16'h0000 |-> txd)
      else $error("line active with zero divisor");
   a_start_len: assert property ($fell(txd) && div == 16'h0001 |-> (!txd) [*8] ##1 (!txd) [*8])
      else $error("start bit length wrong");
   a_irq_masked: assert property (msk == 3'h0 |-> !irq)
      else $error("interrupt while fully masked");
endmodule

// >>> tb/uad_remote.sv
// Purpose: Remote 8N1 serial device facing the data port.
// Assumes: BIT is sixteen times the programmed divisor, in clocks.
// Notes:   A frame with a bad stop bit is dropped, as a real receiver would.
`timescale 1ns/100ps
module uad_remote #(
   parameter int BIT = 16
) (
   input  wire logic       mclk,  // Clock.
   input  wire logic       txd,   // Line from the block.
   output logic            rxd,   // Line to the block, idle high.
   output logic      [7:0] got,   // Received character.
   output logic            gotStb // One-cycle receive pulse.
);
   initial begin
      rxd = 1'b1;
      gotStb = 1'b0;
   end
   task automatic send(input logic [7:0] ch);
      logic [9:0] f;
      f = {1'b1, ch, 1'b0};
      for (int i = 0; i < 10; i++) begin
         rxd <= f[i];
         repeat (BIT) @(posedge mclk);
      end
   endtask
   always begin
      @(negedge txd);
      repeat (BIT / 2) @(posedge mclk);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT) @(posedge mclk);
         got[i] <= txd;
      end
      repeat (BIT) @(posedge mclk);
      gotStb <= txd;
      @(posedge mclk);
      gotStb <= 1'b0;
   end
endmodule

// >>> tb/uart_data_and_divisor_port_test.sv
// Purpose: Self-checking bench for the data port.
// Assumes: Divisor 1 in traffic tests, so one bit is sixteen clocks.
// Notes:   A small FIFO depth keeps the fill and overflow cases short.
`timescale 1ns/100ps
`include "uad_cfg.svh"
module uart_data_and_divisor_port_test;
   localparam int          DEPTH = 4;
   localparam logic [31:0] A_D = `UAD_ADDR_DATA, A_H = `UAD_ADDR_IER_DLH,
      A_F = `UAD_ADDR_FIFO_CTRL, A_L = `UAD_ADDR_LINE_CTRL, A_S = `UAD_ADDR_LINE_STATUS,
      A_I = `UAD_ADDR_INT_STATUS, A_M = `UAD_ADDR_INT_MASK;
   logic        mclk, nrst, ce, wrStb, rdStb, rxd, txd, irq, gotStb, rdPend = 1'b0;
   logic [31:0] addr;
   logic [15:0] wdata, rdata, r, expQ[$], mskQ[$];
   logic [7:0]  got, c, v[DEPTH+1], txQ[$];
   int          n_errors = 0, checks_done = 0;
   uad_data_port #(.FIFO_DEPTH(DEPTH)) dut (.mclk(mclk), .nrst(nrst), .ce(ce), .addr(addr),
      .wdata(wdata), .wrStb(wrStb), .rdStb(rdStb), .rdata(rdata), .rxd(rxd), .txd(txd),
      .irq(irq));
   uad_remote rem (.mclk(mclk), .txd(txd), .rxd(rxd), .got(got), .gotStb(gotStb));
   task automatic chk(input string nm, input logic [15:0] e, g, m);
      checks_done++;
      if ((g & m) !== (e & m)) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, e & m, g & m);
      end
   endtask
   task automatic bus(input logic w, input logic [31:0] a, input logic [15:0] d, e, m);
      wrStb <= w;
      rdStb <= !w;
      addr <= a;
      wdata <= d;
      if (!w) begin
         expQ.push_back(e);
         mskQ.push_back(m);
      end
      @(posedge mclk);
   endtask
   task automatic idle(input int n);
      wrStb <= 1'b0;
      rdStb <= 1'b0;
      repeat (n) @(posedge mclk);
   endtask
   task automatic end_of_test();
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // Read results are matched in issue order, one cycle after each read strobe.
   always @(posedge mclk) begin
      rdPend <= rdStb;
      if (rdPend === 1'b1) chk("rdata", expQ.pop_front(), rdata, mskQ.pop_front());
      if (gotStb === 1'b1) chk("serial", {8'h00, txQ.pop_front()}, {8'h00, got}, 16'h00ff);
   end
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   initial begin
      repeat (20000) @(posedge mclk);
      n_errors++;
      end_of_test();
   end
   initial begin
      {nrst, wrStb, rdStb, addr, wdata} = '0;
      ce = 1'b1;
      r = 16'($urandom(21864));
      repeat (8) @(posedge mclk);
      nrst <= 1'b1;
      @(posedge mclk);
      bus(0, A_D, 0, 0, 16'hffff);
      bus(0, A_M, 0, 0, 16'hffff);
      bus(0, 32'h50001010, 0, 0, 16'hffff);
      r = 16'($urandom);
      bus(1, A_L, 16'h0080, 0, 0);
      bus(1, A_D, r, 0, 0);
      bus(1, A_H, ~r, 0, 0);
      bus(0, A_D, 0, {8'h00, r[7:0]}, 16'hffff);
      bus(0, A_H, 0, {8'h00, ~r[7:0]}, 16'hffff);
      bus(1, A_D, 0, 0, 0);
      bus(1, A_H, 0, 0, 0);
      bus(1, A_L, 0, 0, 0);
      // With the baud clock stopped the character must wait in the holding register.
      c = 8'($urandom);
      bus(1, A_D, {8'hff, c}, 0, 0);
      idle(300);
      bus(0, A_S, 0, 0, 16'h0020);
      txQ.push_back(c);
      bus(1, A_L, 16'h0080, 0, 0);
      bus(1, A_D, 16'h0001, 0, 0);
      bus(1, A_L, 0, 0, 0);
      idle(180);
      bus(0, A_S, 0, 16'h0020, 16'h0020);
      c = 8'($urandom);
      txQ.push_back(c);
      bus(1, A_D, c, 0, 0);
      idle(4);
      bus(1, A_D, 16'($urandom), 0, 0);
      bus(0, A_S, 0, 0, 16'h0020);
      c = 8'($urandom);
      txQ.push_back(c);
      bus(1, A_D, c, 0, 0);
      bus(1, A_M, 16'h0001, 0, 0);
      idle(340);
      for (int i = 0; i < 2; i++) begin
         v[i] = 8'($urandom);
         rem.send(v[i]);
      end
      idle(10);
      chk("irq", 16'h0001, {15'h0000, irq}, 16'h0001);
      bus(0, A_S, 0, 16'h0003, 16'h0003);
      bus(0, A_D, 0, {8'h00, v[1]}, 16'hffff);
      bus(0, A_S, 0, 0, 16'h0003);
      bus(0, A_I, 0, 16'h0003, 16'h0003);
      idle(2);
      chk("irq", 16'h0000, {15'h0000, irq}, 16'h0001);
      ce <= 1'b0;
      bus(1, A_M, 16'h0007, 0, 0);
      ce <= 1'b1;
      bus(0, A_M, 0, 16'h0001, 16'hffff);
      bus(1, A_F, 16'h0001, 0, 0);
      idle(2);
      for (int i = 0; i <= DEPTH; i++) begin
         v[i] = 8'($urandom);
         rem.send(v[i]);
      end
      idle(10);
      bus(0, A_S, 0, 16'h0003, 16'h0003);
      for (int i = 0; i < DEPTH; i++) bus(0, A_D, 0, {8'h00, v[i]}, 16'hffff);
      bus(0, A_D, 0, 0, 16'hffff);
      c = 8'($urandom);
      txQ.push_back(c);
      bus(1, A_D, c, 0, 0);
      idle(4);
      for (int i = 0; i < DEPTH + 2; i++) begin
         c = 8'($urandom);
         bus(1, A_D, c, 0, 0);
         if (i < DEPTH) txQ.push_back(c);
      end
      idle(170 * (DEPTH + 1) + 20);
      chk("tx left", 16'h0000, 16'(txQ.size()), 16'hffff);
      end_of_test();
   end
endmodule
bind uad_data_port uad_data_port_chk chk (.mclk(mclk), .nrst(nrst), .ce(ce), .addr(addr),
   .wdata(wdata), .wrStb(wrStb), .rdStb(rdStb), .rdata(rdata), .rxd(rxd), .txd(txd),
   .irq(irq));
